//--- verilog/qsr_pkg.sv
// qsr_pkg: constants for the questionable status word and top status byte
// assumes: compiled ahead of the questionable status modules
package qsr_pkg;
   // ************************************************************
   // questionable word layout
   // ************************************************************
   localparam int unsigned QSR_QW_WIDTH     = 16;
   localparam int unsigned QSR_BIT_UNLEVEL  = 10;
   localparam int unsigned QSR_BIT_UNLOCK   = 11;
   localparam int unsigned QSR_BIT_NOREF    = 12;
   localparam logic [15:0] QSR_QW_RESET     = 16'h0000;
   localparam logic [15:0] QSR_QW_USED_MASK = 16'h1c00;
   // ************************************************************
   // top status byte layout
   // ************************************************************
   localparam int unsigned QSR_SB_WIDTH     = 8;
   localparam int unsigned QSR_SB_QUESTIONABLE_CONDITION      = 3;
   localparam int unsigned QSR_SB_SRQ       = 6;
   localparam logic [7:0]  QSR_SB_RESET     = 8'h00;
   localparam logic [7:0]  QSR_MASK_RESET   = 8'h00;
   localparam logic [7:0]  QSR_SB_USED_MASK = 8'h3d;
   // ************************************************************
   // pin input filter
   // ************************************************************
   localparam int unsigned QSR_SYNC_STAGES  = 3;
endpackage

//--- verilog/qsr_sync.sv
// qsr_sync: three-stage synchroniser, change accepted when stages 1 and 2 agree
// assumes: input is asynchronous to mclk_i
`timescale 1ns/100ps
module qsr_sync
   import qsr_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   output logic      level_o
);
   logic [QSR_SYNC_STAGES-1:0] stage_r;
   logic                       level_r;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         stage_r <= '0;
      end else begin
         stage_r <= {stage_r[QSR_SYNC_STAGES-2:0], async_i};
      end
   end

   // stage 0 feeds only stage 1
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         level_r <= 1'b0;
      end else if (stage_r[1] == stage_r[2]) begin
         level_r <= stage_r[2];
      end
   end

   assign level_o = level_r;
endmodule

//--- verilog/qsr_top.sv
// qsr_top: questionable condition word, status byte summary and service request
// assumes: condition pins asynchronous; query/mask ports driven on mclk_i
`timescale 1ns/100ps
module qsr_top
   import qsr_pkg::*;
(
   input  wire logic                    mclk_i,
   input  wire logic                    rst_i,
   input  wire logic                    output_level_loop_unlevel_i,
   input  wire logic                    synth_unlock_i,
   input  wire logic                    ext_ref_lost_i,
   input  wire logic [QSR_SB_WIDTH-1:0] other_status_i,
   input  wire logic                    mask_wr_i,
   input  wire logic [QSR_SB_WIDTH-1:0] mask_wdata_i,
   input  wire logic                    query_i,
   output logic      [QSR_QW_WIDTH-1:0] questionable_word_o,
   output logic                         query_valid_o,
   output logic      [QSR_SB_WIDTH-1:0] top_status_byte_o,
   output logic      [QSR_SB_WIDTH-1:0] service_request_mask_o,
   output logic                         service_request_summary_o
);
   // ************************************************************
   // condition pin synchronisers
   // ************************************************************
   logic [2:0] pin_raw;
   logic [2:0] pin_lvl;
   assign pin_raw = {ext_ref_lost_i, synth_unlock_i, output_level_loop_unlevel_i};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         qsr_sync u_sync (
            .mclk_i  (mclk_i),
            .rst_i   (rst_i),
            .async_i (pin_raw[gi]),
            .level_o (pin_lvl[gi])
         );
      end
   endgenerate

   // ************************************************************
   // questionable condition word
   // ************************************************************
   logic [QSR_QW_WIDTH-1:0] cond_r;
   logic [QSR_QW_WIDTH-1:0] cond_nxt;

   always_comb begin
      cond_nxt                  = '0;
      cond_nxt[QSR_BIT_UNLEVEL] = pin_lvl[0];
      cond_nxt[QSR_BIT_UNLOCK]  = pin_lvl[1];
      cond_nxt[QSR_BIT_NOREF]   = pin_lvl[2];
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cond_r <= QSR_QW_RESET;
      end else begin
         cond_r <= cond_nxt;
      end
   end

   AST_UNUSED_ZERO: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (cond_r & ~QSR_QW_USED_MASK) == '0)
      else $error("unused questionable bit set");

   AST_UNLEVEL: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      cond_r[QSR_BIT_UNLEVEL] == $past(pin_lvl[0]))
      else $error("unlevel bit does not follow pin");

   AST_UNLOCK: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      cond_r[QSR_BIT_UNLOCK] == $past(pin_lvl[1]))
      else $error("unlock bit does not follow pin");

   AST_NOREF: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      cond_r[QSR_BIT_NOREF] == $past(pin_lvl[2]))
      else $error("noref bit does not follow pin");

   AST_UNLEVEL_RISE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      $rose(pin_raw[0]) ##1 pin_raw[0] [*4] |=> cond_r[QSR_BIT_UNLEVEL])
      else $error("unlevel bit late after pin rise");

   AST_UNLEVEL_FALL: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      $fell(pin_raw[0]) ##1 !pin_raw[0] [*4] |=> !cond_r[QSR_BIT_UNLEVEL])
      else $error("unlevel bit late after pin fall");

   AST_UNLOCK_RISE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      $rose(pin_raw[1]) ##1 pin_raw[1] [*4] |=> cond_r[QSR_BIT_UNLOCK])
      else $error("unlock bit late after pin rise");

   AST_UNLOCK_FALL: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      $fell(pin_raw[1]) ##1 !pin_raw[1] [*4] |=> !cond_r[QSR_BIT_UNLOCK])
      else $error("unlock bit late after pin fall");

   AST_NOREF_RISE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      $rose(pin_raw[2]) ##1 pin_raw[2] [*4] |=> cond_r[QSR_BIT_NOREF])
      else $error("noref bit late after pin rise");

   AST_NOREF_FALL: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      $fell(pin_raw[2]) ##1 !pin_raw[2] [*4] |=> !cond_r[QSR_BIT_NOREF])
      else $error("noref bit late after pin fall");

   // ************************************************************
   // condition query
   // ************************************************************
   logic [QSR_QW_WIDTH-1:0] qword_r;
   logic                    qvalid_r;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         qword_r  <= QSR_QW_RESET;
         qvalid_r <= 1'b0;
      end else begin
         qvalid_r <= query_i;
         if (query_i) begin
            qword_r <= cond_r;
         end
      end
   end

   AST_QUERY: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      query_i |=> query_valid_o && questionable_word_o == $past(cond_r))
      else $error("query word wrong");

   AST_QUERY_PULSE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !query_i |=> !query_valid_o)
      else $error("query valid without query");

   AST_QUERY_HOLD: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !query_i |=> $stable(questionable_word_o))
      else $error("query word changed without query");

   AST_WORD_UNUSED: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (questionable_word_o & ~QSR_QW_USED_MASK) == '0)
      else $error("unused bit in returned word");

   // ************************************************************
   // service request mask
   // ************************************************************
   logic [QSR_SB_WIDTH-1:0] mask_r;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mask_r <= QSR_MASK_RESET;
      end else if (mask_wr_i) begin
         mask_r <= mask_wdata_i;
      end
   end

   AST_MASK_WRITE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      mask_wr_i |=> service_request_mask_o == $past(mask_wdata_i))
      else $error("mask write not taken");

   AST_MASK_HOLD: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !mask_wr_i |=> $stable(service_request_mask_o))
      else $error("mask changed without write");

   // ************************************************************
   // top status byte and service request
   // ************************************************************
   logic [QSR_SB_WIDTH-1:0] sb_r;
   logic [QSR_SB_WIDTH-1:0] sb_nxt;
   logic                    srq_r;

   always_comb begin
      sb_nxt               = other_status_i & QSR_SB_USED_MASK;
      sb_nxt[QSR_SB_QUESTIONABLE_CONDITION]  = |cond_r;
      sb_nxt[QSR_SB_SRQ]   = |(sb_r & mask_r & ~(8'h01 << QSR_SB_SRQ));
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sb_r  <= QSR_SB_RESET;
         srq_r <= 1'b0;
      end else begin
         sb_r  <= sb_nxt;
         srq_r <= sb_nxt[QSR_SB_SRQ];
      end
   end

   AST_SUMMARY: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      sb_r[QSR_SB_QUESTIONABLE_CONDITION] == $past(|cond_r))
      else $error("summary bit wrong");

   AST_SB_OTHER: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !$past(rst_i) |->
         ((sb_r ^ $past(other_status_i)) & QSR_SB_USED_MASK & ~(8'h01 << QSR_SB_QUESTIONABLE_CONDITION)) == '0)
      else $error("other status bits wrong");

   AST_SRQ: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (mask_r[QSR_SB_QUESTIONABLE_CONDITION] && sb_r[QSR_SB_QUESTIONABLE_CONDITION]) |=> sb_r[QSR_SB_SRQ])
      else $error("service request missing");

   AST_SRQ_FULL: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      sb_r[QSR_SB_SRQ] == ($past(sb_r & mask_r & ~(8'h01 << QSR_SB_SRQ)) != '0))
      else $error("service request bit wrong");

   AST_SRQ_OUT: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      service_request_summary_o == sb_r[QSR_SB_SRQ])
      else $error("summary output mismatch");

   assign questionable_word_o       = qword_r;
   assign query_valid_o             = qvalid_r;
   assign top_status_byte_o         = sb_r;
   assign service_request_mask_o    = mask_r;
   assign service_request_summary_o = srq_r;
endmodule

//--- tb/qsr_ctrl_model.sv
// qsr_ctrl_model: remote controller issuing queries and mask writes
// assumes: tasks are entered just after a falling edge of mclk_i
`timescale 1ns/100ps
module qsr_ctrl_model (
   input  wire logic       mclk_i,
   output logic            query_o,
   output logic            mask_wr_o,
   output logic      [7:0] mask_wdata_o
);
   initial begin
      query_o      = 1'b0;
      mask_wr_o    = 1'b0;
      mask_wdata_o = 8'h00;
   end
   // word obtained only by query, n back to back
   task automatic query(input int n);
      query_o = 1'b1;
      repeat (n) @(negedge mclk_i);
      query_o = 1'b0;
   endtask
   task automatic write_mask(input logic [7:0] m);
      mask_wr_o    = 1'b1;
      mask_wdata_o = m;
      @(negedge mclk_i);
      mask_wr_o    = 1'b0;
      // released data no longer shows the last value
      mask_wdata_o = ~m;
   endtask
endmodule

//--- tb/questionable_status_register_tb.sv
// questionable_status_register_tb: self-checking bench for qsr_top
// assumes: qsr_ctrl_model plays the remote controller
`timescale 1ns/100ps
module questionable_status_register_tb;
   import qsr_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rst_i  = 1'b1;
   logic  [2:0] pins   = 3'h0;
   logic  [7:0] other  = 8'h00;
   logic        qry, mwr, qv, srs;
   logic  [7:0] mwd, sb, mrb, e_sb, msk;
   logic [15:0] qw;
   logic [15:0] exp_q[$];
   int          n_errors = 0;
   int          checks   = 0;
   int          cyc      = 0;
   initial forever #2 mclk_i = ~mclk_i;
   qsr_ctrl_model i_ctrl (.mclk_i(mclk_i), .query_o(qry), .mask_wr_o(mwr), .mask_wdata_o(mwd));
   qsr_top i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .output_level_loop_unlevel_i(pins[0]),
      .synth_unlock_i(pins[1]), .ext_ref_lost_i(pins[2]), .other_status_i(other),
      .mask_wr_i(mwr), .mask_wdata_i(mwd), .query_i(qry), .questionable_word_o(qw),
      .query_valid_o(qv), .top_status_byte_o(sb), .service_request_mask_o(mrb),
      .service_request_summary_o(srs));
   task automatic cmp16(input logic [15:0] a, input logic [15:0] e);
      checks++;
      if (a !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   task automatic cmp8(input logic [7:0] a, input logic [7:0] e);
      checks++;
      if (a !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // answer monitor: oldest noted word per valid pulse
   always @(negedge mclk_i) begin
      if (qv === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, qw, 16'h0000);
         end else begin
            cmp16(qw, exp_q.pop_front());
         end
      end
   end
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      void'($urandom(32'h7bec759b));
      repeat (20) @(negedge mclk_i);
      rst_i = 1'b0;
      @(negedge mclk_i);
      cmp8(sb, 8'h00);
      for (int i = 0; i < 12; i++) begin
         pins  = (i < 8) ? 3'(i) : 3'($urandom);
         other = 8'($urandom);
         msk   = 8'($urandom);
         i_ctrl.write_mask(msk);
         repeat (8) @(negedge mclk_i);
         // reference loss driven on pins[2] as well, so bit 12 is checked
         exp_q.push_back({3'h0, pins, 10'h000});
         exp_q.push_back({3'h0, pins, 10'h000});
         i_ctrl.query(2);
         e_sb    = (other & 8'h35) | {4'h0, |pins, 3'h0};
         e_sb[6] = |(e_sb & msk);
         cmp8(sb, e_sb);
         cmp8(mrb, msk);
         cmp8({7'h0, srs}, {7'h0, e_sb[6]});
      end
      repeat (4) @(negedge mclk_i);
      cmp16(16'(exp_q.size()), 16'h0000);
      final_report();
   end
endmodule
